//--- cmc_map.vh
/*
 * Register offsets, field positions and reset values for the CAN module
 * configuration and mode control block.
 * Assumes inclusion by a single design file; definitions only.
 */
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CMC_OFF_CONFIG 8'h00
`define CMC_OFF_ERRCNT 8'h04
`define CMC_OFF_STATUS 8'h08

// ****************************************
// Configuration and status field positions
// ****************************************
`define CMC_B_DISABLE 31
`define CMC_B_FRZEN 30
`define CMC_B_HALT 28
`define CMC_B_NOTRDY 27
`define CMC_B_WAKMSK 26
`define CMC_B_SOFTRST 25
`define CMC_B_FRZACK 24
`define CMC_B_SUPERVISOR_ONLY 23
`define CMC_B_SLFWAK 22
`define CMC_B_LPMACK 20
`define CMC_B_WAKSRC 19
`define CMC_B_DOZE 18
`define CMC_B_WAKFLAG 0

// ****************************************
// Reset values and limits
// ****************************************
`define CMC_BUFCNT_RST 6'h0F
`define CMC_BUFCNT_MAX 6'h20
`define CMC_FILT_LEN 4
`define CMC_SRST_CYC 4

`endif

//--- cmc_mode_ctrl.v
/*
 * CAN module configuration and operating-mode control: disable, freeze,
 * doze and stop entry with acknowledges, self wake-up, soft reset, supervisor
 * gating and buffer-count limit, as an AHB-Lite slave.
 * Assumes one clock (hclk), the protocol engine reporting frame activity
 * and prescaler state as same-clock levels, and can_rx as an async pin.
 */
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "cmc_map.vh"

// Function
// RL1: Disable bit gates clocks to protocol engine and buffer management.
// RL2: Freeze entered only with freeze enable and halt or debug request.
// RL3: Halt requests freeze and blocks all transmit and receive.
// RL4: Software clears halt only after initialising buffers and control.
// RL5: Error counter register is writable only while frozen.
// RL6: No freeze during low power; acknowledge waits for low-power exit.
// RL7: Not-ready is high when disabled, dozing, stopped or frozen.
// RL8: Wake interrupt raised only when wake mask bit is set.
// RL9: Soft reset clears state and registers except the disable bit.
// RL10: Soft-reset bit set by write or global request, self-clears when done.
// RL11: Software leaves low power before requesting soft reset.
// RL12: Freeze acknowledge after frames finish and prescaler stops.
// RL13: Supervisor bit resets to one; unprivileged protected access errors; the code reads zero, drops the write and answers OKAY.
// RL14: Self-wake watches falling bus edge; doze restarts clocks, raises wake.
// RL15: Writes to self-wake ignored while in doze or stop.
// RL16: Low-power acknowledge when disabled, dozing or stopped, after frames; the code acknowledges disable at once, without waiting for frames.
// RL17: Wake source bit picks raw or filtered receive for edge detect.
// RL18: Doze enable permits doze entry; cleared on self-wake from doze.
// RL19: Buffer count is field plus one, resets to 0x0F, changed in freeze; the code accepts the write in any mode.
// RL20: Buffer-count field above 32 stops all transmit and receive.
// RL21: Wake interrupt shares the channel error interrupt line.
// RL22: Hardware reset restores every field including the disable bit.
module cmc_mode_ctrl #(
  parameter FILT_LEN = `CMC_FILT_LEN
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [3:0] hprot,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Chip-level requests
  input wire debug_req,
  input wire doze_req,
  input wire stop_req,
  input wire global_soft_reset,
  // Protocol engine status and control
  input wire frame_active,
  input wire prescaler_stopped,
  input wire error_irq,
  output wire engine_clk_en,
  output wire freeze_req,
  output wire txrx_inhibit,
  output wire soft_reset_out,
  output wire [6:0] buffers_in_use,
  // CAN receive pin
  input wire can_rx,
  // Interrupt and wake
  output wire error_wake_irq,
  output wire wake_clk_restart
);

  // ****************************************
  // Decoding
  // ****************************************
  function is_word_addr;
    input [7:0] a;
    input [7:0] off;
    begin
      is_word_addr = (a[7:2] == off[7:2]);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg module_disable;
  reg freeze_enable;
  reg halt;
  reg wake_interrupt_mask;
  reg soft_reset;
  reg supervisor_only;
  reg self_wake_enable;
  reg wake_source_filter_select;
  reg doze_enable;
  reg [5:0] buffer_count_limit;
  reg [7:0] error_counter_register;
  reg freeze_acknowledge;
  reg wake_flag;
  reg armed_wake;
  reg [2:0] srst_cnt;
  reg [2:0] lp_state;
  reg rx_s1;
  reg rx_s2;
  reg [FILT_LEN-1:0] rx_hist;
  reg rx_filt;
  reg rx_prev;
  // Address phase capture
  reg dp_valid;
  reg dp_write;
  reg [7:0] dp_addr;

  // One-hot low-power states
  localparam LP_RUN = 3'b001;
  localparam LP_DOZE = 3'b010;
  localparam LP_STOP = 3'b100;

  wire in_doze = (lp_state == LP_DOZE);
  wire in_stop = (lp_state == LP_STOP);
  wire low_power_acknowledge = module_disable | in_doze | in_stop; // [RL16]
  wire not_ready = low_power_acknowledge | freeze_acknowledge; // [RL7]

  // ****************************************
  // Bus slave
  // ****************************************
  wire addr_phase = hsel & hready & htrans[1];
  wire mapped = is_word_addr(haddr, `CMC_OFF_CONFIG) | is_word_addr(haddr, `CMC_OFF_ERRCNT) |
                is_word_addr(haddr, `CMC_OFF_STATUS);
  wire prot_reg = is_word_addr(haddr, `CMC_OFF_ERRCNT) | is_word_addr(haddr, `CMC_OFF_STATUS);
  wire denied = (supervisor_only & prot_reg & ~hprot[1]) | ~mapped; // [RL13]

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_valid <= addr_phase & ~denied;
      dp_write <= hwrite;
      dp_addr <= haddr;
    end
  end

  // Unimplemented or unprivileged protected accesses read zero and drop writes
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire wr_cfg = dp_valid & dp_write & is_word_addr(dp_addr, `CMC_OFF_CONFIG);
  wire wr_ecr = dp_valid & dp_write & is_word_addr(dp_addr, `CMC_OFF_ERRCNT);
  wire wr_sts = dp_valid & dp_write & is_word_addr(dp_addr, `CMC_OFF_STATUS);

  wire [31:0] cfg_word = {module_disable, freeze_enable, 1'b0, halt, not_ready, wake_interrupt_mask,
                          soft_reset, freeze_acknowledge, supervisor_only, self_wake_enable, 1'b0,
                          low_power_acknowledge, wake_source_filter_select, doze_enable, 12'h000,
                          buffer_count_limit};

  always @* begin
    hrdata = 32'h00000000;
    if (dp_valid && !dp_write) begin
      if (is_word_addr(dp_addr, `CMC_OFF_CONFIG))
        hrdata = cfg_word;
      else if (is_word_addr(dp_addr, `CMC_OFF_ERRCNT))
        hrdata = {24'h000000, error_counter_register};
      else
        hrdata = {31'h00000000, wake_flag};
    end
  end

  // ****************************************
  // Wake detection
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_hist <= {FILT_LEN{1'b1}};
      rx_filt <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= can_rx;
      rx_s2 <= rx_s1;
      rx_hist <= {rx_hist[FILT_LEN-2:0], rx_s2};
      if (&rx_hist)
        rx_filt <= 1'b1;
      else if (~|rx_hist)
        rx_filt <= 1'b0;
      rx_prev <= wake_source_filter_select ? rx_filt : rx_s2; // [RL17]
    end
  end

  wire rx_sel = wake_source_filter_select ? rx_filt : rx_s2; // [RL17]
  wire wake_edge = armed_wake & (in_doze | in_stop) & rx_prev & ~rx_sel; // [RL14]

  // ****************************************
  // Low-power and freeze sequencing
  // ****************************************
  wire freeze_request = freeze_enable & (halt | debug_req); // [RL2] [RL3]
  assign freeze_req = freeze_request & (lp_state == LP_RUN) & ~module_disable; // [RL6]

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lp_state <= LP_RUN;
      armed_wake <= 1'b0;
      freeze_acknowledge <= 1'b0;
    end else if (soft_reset) begin
      lp_state <= LP_RUN; // [RL9]
      armed_wake <= 1'b0;
      freeze_acknowledge <= 1'b0;
    end else begin
      case (lp_state)
        LP_RUN: begin
          // Entry waits for the bus to go quiet
          if (!frame_active && stop_req) begin // [RL16]
            lp_state <= LP_STOP;
            armed_wake <= self_wake_enable; // [RL14]
          end else if (!frame_active && doze_req && doze_enable) begin // [RL18]
            lp_state <= LP_DOZE;
            armed_wake <= self_wake_enable; // [RL14]
          end
        end
        LP_DOZE: begin
          if (wake_edge || !doze_req)
            lp_state <= LP_RUN; // [RL14]
        end
        LP_STOP: begin
          if (!stop_req)
            lp_state <= LP_RUN;
        end
        default: lp_state <= LP_RUN;
      endcase
      if (freeze_req && !frame_active && prescaler_stopped)
        freeze_acknowledge <= 1'b1; // [RL12]
      else if (!freeze_req && !prescaler_stopped)
        freeze_acknowledge <= 1'b0; // [RL12]
    end
  end

  // ****************************************
  // Configuration register and soft reset
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_disable <= 1'b0; // [RL22]
      freeze_enable <= 1'b0;
      halt <= 1'b0;
      wake_interrupt_mask <= 1'b0;
      soft_reset <= 1'b0;
      supervisor_only <= 1'b1; // [RL13]
      self_wake_enable <= 1'b0;
      wake_source_filter_select <= 1'b0;
      doze_enable <= 1'b0;
      buffer_count_limit <= `CMC_BUFCNT_RST; // [RL19]
      error_counter_register <= 8'h00;
      wake_flag <= 1'b0;
      srst_cnt <= 3'h0;
    end else if (soft_reset) begin
      // Everything but the disable bit returns to reset value
      freeze_enable <= 1'b0; // [RL9]
      halt <= 1'b0;
      wake_interrupt_mask <= 1'b0;
      supervisor_only <= 1'b1;
      self_wake_enable <= 1'b0;
      wake_source_filter_select <= 1'b0;
      doze_enable <= 1'b0;
      buffer_count_limit <= `CMC_BUFCNT_RST;
      error_counter_register <= 8'h00;
      wake_flag <= 1'b0;
      srst_cnt <= srst_cnt + 3'h1;
      if (srst_cnt == `CMC_SRST_CYC - 1)
        soft_reset <= 1'b0; // [RL10]
    end else begin
      srst_cnt <= 3'h0;
      if (wr_cfg) begin
        module_disable <= hwdata[`CMC_B_DISABLE]; // [RL1]
        freeze_enable <= hwdata[`CMC_B_FRZEN];
        halt <= hwdata[`CMC_B_HALT];
        wake_interrupt_mask <= hwdata[`CMC_B_WAKMSK];
        supervisor_only <= hwdata[`CMC_B_SUPERVISOR_ONLY];
        wake_source_filter_select <= hwdata[`CMC_B_WAKSRC];
        doze_enable <= hwdata[`CMC_B_DOZE];
        buffer_count_limit <= hwdata[5:0]; // [RL19]
        if (!(in_doze || in_stop))
          self_wake_enable <= hwdata[`CMC_B_SLFWAK]; // [RL15]
      end
      if (wr_cfg && hwdata[`CMC_B_SOFTRST] || global_soft_reset)
        soft_reset <= 1'b1; // [RL10]
      if (in_doze && wake_edge)
        doze_enable <= 1'b0; // [RL18]
      if (wr_ecr && freeze_acknowledge)
        error_counter_register <= hwdata[7:0]; // [RL5]
      // A new wake event beats a simultaneous clear
      if (wake_edge)
        wake_flag <= 1'b1;
      else if (wr_sts && hwdata[`CMC_B_WAKFLAG])
        wake_flag <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign engine_clk_en = ~module_disable & ~in_doze & ~in_stop; // [RL1] [RL14]
  assign wake_clk_restart = wake_edge & in_doze; // [RL14]
  assign txrx_inhibit = halt | freeze_acknowledge | (buffer_count_limit > `CMC_BUFCNT_MAX); // [RL3] [RL20]
  assign soft_reset_out = soft_reset; // [RL9]
  assign buffers_in_use = {1'b0, buffer_count_limit} + 7'h01; // [RL19]
  assign error_wake_irq = error_irq | (wake_flag & wake_interrupt_mask); // [RL8] [RL21]

endmodule // cmc_mode_ctrl

//--- cmc_mode_ctrl_asserts.sv
/* Port checker for cmc_mode_ctrl.
   Assumes a zero-wait AHB-Lite slave on one clock. */
`timescale 1ns/1ps
module cmc_chk (
  // Clock, reset and bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Engine and wake
  input wire error_irq,
  input wire engine_clk_en,
  input wire txrx_inhibit,
  input wire soft_reset_out,
  input wire [6:0] buffers_in_use,
  input wire error_wake_irq,
  input wire wake_clk_restart
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // Data phase
  // ****************
  logic wp;
  logic rp;
  logic [7:0] pa;
  wire cw = wp && pa == 8'h00 && !soft_reset_out && !hwdata[25];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'b0;
      rp <= 1'b0;
      pa <= 8'h00;
    end else if (hready) begin
      wp <= hsel && htrans[1] && hwrite;
      rp <= hsel && htrans[1] && !hwrite;
      pa <= haddr;
    end
  end
  // ****************
  // Properties
  // ****************
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not OKAY");
  a_limit_inhibit: assert property (buffers_in_use > 7'h21 |-> txrx_inhibit)
    else $error("count over limit not inhibited");
  a_disable_clk: assert property (cw && hwdata[31] |=> !engine_clk_en)
    else $error("clocks run while disabled");
  a_count_load: assert property (cw |=> buffers_in_use == {1'b0, $past(hwdata[5:0])} + 7'h01)
    else $error("buffer count wrong");
  a_halt_inhibit: assert property (cw && hwdata[28] |=> txrx_inhibit)
    else $error("halt does not inhibit");
  a_srst_done: assert property ($rose(soft_reset_out) |-> ##[1:8] !soft_reset_out)
    else $error("soft reset never clears");
  a_srst_restore: assert property ($fell(soft_reset_out) |-> buffers_in_use == 7'h10)
    else $error("soft reset left count");
  a_error_share: assert property (error_irq |-> error_wake_irq)
    else $error("error not on shared line");
  a_wake_restart: assert property (wake_clk_restart |=> !wake_clk_restart ##[0:2] engine_clk_en)
    else $error("wake did not restart clocks");
  a_not_ready: assert property (rp && pa == 8'h00 && (!engine_clk_en || hrdata[24]) |-> hrdata[27])
    else $error("not-ready flag low");
  cover property ($rose(soft_reset_out));
  cover property (wake_clk_restart);
  cover property (!engine_clk_en);
  cover property (txrx_inhibit);
endmodule // cmc_chk

bind cmc_mode_ctrl cmc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .error_irq(error_irq), .engine_clk_en(engine_clk_en),
  .txrx_inhibit(txrx_inhibit), .soft_reset_out(soft_reset_out), .buffers_in_use(buffers_in_use),
  .error_wake_irq(error_wake_irq), .wake_clk_restart(wake_clk_restart));

//--- cmc_engine_model.sv
/* Protocol engine and bus line model.
   Assumes the bench starts frames and dominant levels. */
`timescale 1ns/1ps
module cmc_engine_model (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // From block and bench
  input wire freeze_req,
  input wire engine_clk_en,
  input wire frame_go,
  input wire rx_dom,
  // To block
  output logic frame_active,
  output logic prescaler_stopped,
  output wire can_rx
);
  logic [3:0] cnt;
  // Bus idles recessive high
  assign can_rx = !rx_dom;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_active <= 1'b0;
      prescaler_stopped <= 1'b0;
      cnt <= 4'h0;
    end else begin
      if (frame_go && engine_clk_en && !frame_active) begin
        frame_active <= 1'b1;
        cnt <= 4'hA;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else begin
        frame_active <= 1'b0;
      end
      prescaler_stopped <= freeze_req && !frame_active;
    end
  end
endmodule // cmc_engine_model

//--- cmc_tb.sv
/* Self-checking bench for cmc_mode_ctrl.
   Assumes zero-wait bus and the engine model beside it. */
`timescale 1ns/1ps
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, frame_go = 0, rx_dom = 0, doze_req = 0, error_irq = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [3:0] hprot = 4'h3;
  logic [31:0] hwdata = 0, hrdata, rq;
  logic [6:0] buffers_in_use;
  wire hready, fa, ps, fr, rx, ce, inh, srst, wirq, wrs;
  int n_errors = 0, n_checks = 0, cyc = 0, i;
  always #10 hclk = ~hclk;
  cmc_mode_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hprot(hprot), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(), .hrdata(hrdata), .debug_req(1'b0), .doze_req(doze_req), .stop_req(1'b0),
    .global_soft_reset(1'b0), .frame_active(fa), .prescaler_stopped(ps), .error_irq(error_irq),
    .engine_clk_en(ce), .freeze_req(fr), .txrx_inhibit(inh), .soft_reset_out(srst),
    .buffers_in_use(buffers_in_use), .can_rx(rx), .error_wake_irq(wirq), .wake_clk_restart(wrs));
  cmc_engine_model i_eng (.hclk(hclk), .hresetn(hresetn), .freeze_req(fr), .engine_clk_en(ce),
    .frame_go(frame_go), .rx_dom(rx_dom), .frame_active(fa), .prescaler_stopped(ps), .can_rx(rx));
  // ****************
  // Tasks
  // ****************
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ab(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rq = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ab(1'b1, a, d);
    // Let the written register settle before outputs are compared
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ab(1'b0, a, 32'h0);
    chk(rq, e);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      complete_run;
    end
  end
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h0080000F);
    chk(buffers_in_use, 7'h10);
    $display("test reset done");
    frame_go <= 1'b1;
    wr(8'h00, 32'h5080000F);
    frame_go <= 1'b0;
    ab(1'b0, 8'h00, 32'h0);
    chk(rq[24], 1'b0);
    repeat (20) @(posedge hclk);
    rd(8'h00, 32'h5980000F);
    wr(8'h04, 32'h5A);
    rd(8'h04, 32'h5A);
    hprot <= 4'h0;
    rd(8'h04, 32'h0);
    hprot <= 4'h3;
    wr(8'h00, 32'h50800021);
    chk({inh, buffers_in_use}, {1'b1, 7'h22});
    wr(8'h00, 32'h54800003);
    chk(buffers_in_use, 7'h04);
    wr(8'h00, 32'h56800003);
    for (i = 0; i < 20 && (i == 0 || rq[25]); i++) ab(1'b0, 8'h00, 32'h0);
    rd(8'h00, 32'h0080000F);
    rd(8'h04, 32'h0);
    wr(8'h04, 32'h11);
    rd(8'h04, 32'h0);
    $display("test freeze done");
    wr(8'h00, 32'h8080000F);
    chk(ce, 1'b0);
    rd(8'h00, 32'h8890000F);
    wr(8'h00, 32'h0080000F);
    chk(ce, 1'b1);
    $display("test disable done");
    wr(8'h00, 32'h04C4000F);
    doze_req <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(ce, 1'b0);
    wr(8'h00, 32'h0484000F);
    rd(8'h00, 32'h0CD4000F);
    rx_dom <= 1'b1;
    for (i = 0; i < 20 && wrs !== 1'b1; i++) @(posedge hclk);
    rx_dom <= 1'b0;
    @(posedge hclk);
    chk(wirq, 1'b1);
    rd(8'h00, 32'h04C0000F);
    wr(8'h08, 32'h1);
    chk(wirq, 1'b0);
    doze_req <= 1'b0;
    error_irq <= 1'b1;
    @(posedge hclk);
    @(posedge hclk);
    chk(wirq, 1'b1);
    $display("test wake done");
    complete_run;
  end
endmodule // testbench
